// ===== pkg/scsi_int_status_defines.vh
// Constants for the SCSI interrupt status encoder
// Function
// - Reselect done: code 0x10, connected as target.
// - Select done: code 0x11, connected as initiator.
// - Target command done: 0x13 without attention, 0x14 with attention.
// - Translate address done: code 0x15.
// - Select-and-transfer done as initiator: code 0x16.
// - Transfer done outside message-in: 0x18 plus requested phase.
// - Reserved codes 0x12, 0x17, 0x25, 0x26 are never produced.
// - Message-in pause with acknowledge held: code 0x20.
// - Save-data-pointer message during select-and-transfer: code 0x21.
// - Select or reselect aborted while disconnected: code 0x22.
// - Target receive/send halted: 0x23 without attention, 0x24 with.
// - Advanced-mode mismatched reselection: 0x27, hold acknowledge, expose ID and LUN.
// - Transfer aborted as initiator: 0x28 plus requested phase.
// - Invalid command in any state: code 0x40.
// - Unexpected bus free as initiator: 0x41, become disconnected.
// - Select or reselect timeout: 0x42, stay disconnected.
// - Parity error: 0x43 without attention, 0x44 with attention.
// - Logical address beyond disk boundaries: code 0x45.
// - Non-advanced mismatched reselection: 0x46, connected as initiator.
// - Incorrect status byte in select-and-transfer: code 0x47.
// - Unexpected phase as initiator: 0x48 plus requested phase.
// - Phase code order is message, control/data, input/output; 000 data out.
// - Status holds unchanged from interrupt until host read or reset.
`ifndef SCSI_INT_STATUS_DEFINES_VH
`define SCSI_INT_STATUS_DEFINES_VH

// ***************************************
// Groups (upper nibble)
// ***************************************
`define GRP_DONE 4'h1
`define GRP_PAUSE 4'h2
`define GRP_TERM 4'h4

// ***************************************
// Event numbers (one-hot index)
// ***************************************
`define EV_RESEL_DONE 5'd0
`define EV_SEL_DONE 5'd1
`define EV_TGT_DONE 5'd2
`define EV_XLATE_DONE 5'd3
`define EV_SAT_DONE 5'd4
`define EV_XFER_DONE 5'd5
`define EV_MSGIN_PAUSE 5'd6
`define EV_SAVE_PTR 5'd7
`define EV_SEL_ABORT 5'd8
`define EV_TGT_HALT 5'd9
`define EV_RESEL_MISMATCH_ADV 5'd10
`define EV_XFER_ABORT 5'd11
`define EV_INVALID_CMD 5'd12
`define EV_BUS_FREE 5'd13
`define EV_SEL_TIMEOUT 5'd14
`define EV_PARITY_ERR 5'd15
`define EV_ADDR_RANGE 5'd16
`define EV_RESEL_MISMATCH 5'd17
`define EV_BAD_STATUS 5'd18
`define EV_BAD_PHASE 5'd19
`define EV_COUNT 20

// ***************************************
// Connection states and reset values
// ***************************************
`define CONN_DISC 2'd0
`define CONN_TARGET 2'd1
`define CONN_INIT 2'd2
`define STATUS_RESET 8'h00
`define FLAG_RESET 1'b0
`define SOURCE_RESET 3'h0

`endif

// ===== hw/scsi_interrupt_status_encoder.v
// SCSI interrupt status encoder: prioritised event to status code, held until read
`timescale 1ns/1ps
`include "scsi_int_status_defines.vh"

module scsi_interrupt_status_encoder #(
   parameter NUM_EVENTS = `EV_COUNT
) (
   input wire core_clk_i,
   input wire srst_i,
   input wire clk_en_i,
   input wire [NUM_EVENTS-1:0] event_i,
   input wire attention_i,
   input wire [2:0] phase_code_field_i,
   input wire [2:0] resel_id_i,
   input wire [2:0] resel_lun_i,
   input wire status_read_i,
   output reg [7:0] status_code_bits_o,
   output reg interrupt_request_o,
   output reg [1:0] conn_state_o,
   output reg ack_hold_o,
   output reg [2:0] source_id_o,
   output reg [2:0] source_lun_o
);

   // ***************************************
   // Event encoding
   // ***************************************
   // Phase input already ordered message, control/data, input/output
   function [7:0] encode;
      input [4:0] ev;
      input atn;
      input [2:0] ph;
      begin
         case (ev)
            `EV_RESEL_DONE: encode = {`GRP_DONE, 4'h0};
            `EV_SEL_DONE: encode = {`GRP_DONE, 4'h1};
            `EV_TGT_DONE: encode = {`GRP_DONE, atn ? 4'h4 : 4'h3};
            `EV_XLATE_DONE: encode = {`GRP_DONE, 4'h5};
            `EV_SAT_DONE: encode = {`GRP_DONE, 4'h6};
            `EV_XFER_DONE: encode = {`GRP_DONE, 1'b1, ph};
            `EV_MSGIN_PAUSE: encode = {`GRP_PAUSE, 4'h0};
            `EV_SAVE_PTR: encode = {`GRP_PAUSE, 4'h1};
            `EV_SEL_ABORT: encode = {`GRP_PAUSE, 4'h2};
            `EV_TGT_HALT: encode = {`GRP_PAUSE, atn ? 4'h4 : 4'h3};
            `EV_RESEL_MISMATCH_ADV: encode = {`GRP_PAUSE, 4'h7};
            `EV_XFER_ABORT: encode = {`GRP_PAUSE, 1'b1, ph};
            `EV_INVALID_CMD: encode = {`GRP_TERM, 4'h0};
            `EV_BUS_FREE: encode = {`GRP_TERM, 4'h1};
            `EV_SEL_TIMEOUT: encode = {`GRP_TERM, 4'h2};
            `EV_PARITY_ERR: encode = {`GRP_TERM, atn ? 4'h4 : 4'h3};
            `EV_ADDR_RANGE: encode = {`GRP_TERM, 4'h5};
            `EV_RESEL_MISMATCH: encode = {`GRP_TERM, 4'h6};
            `EV_BAD_STATUS: encode = {`GRP_TERM, 4'h7};
            `EV_BAD_PHASE: encode = {`GRP_TERM, 1'b1, ph};
            // Unused numbers fall back to invalid command, never a reserved code
            default: encode = {`GRP_TERM, 4'h0};
         endcase
      end
   endfunction

   // ***************************************
   // Priority pick: lowest event number wins
   // ***************************************
   // A ripple of "something lower is set" terms: each event looks only at
   // its neighbour, so the event count can grow without new logic
   wire [NUM_EVENTS-1:0] seen_below;
   wire [NUM_EVENTS-1:0] winner;
   wire any_event;
   wire [4:0] pick;

   genvar g;
   generate
      for (g = 0; g < NUM_EVENTS; g = g + 1) begin : pick_chain
         if (g == 0) begin : first
            assign seen_below[g] = 1'b0;
         end else begin : rest
            assign seen_below[g] = seen_below[g-1] | event_i[g-1];
         end
         assign winner[g] = event_i[g] & ~seen_below[g];
      end
   endgenerate

   // One-hot winner to event number
   // At most one bit is set, so the loop order does not matter
   function [4:0] onehot_index;
      input [NUM_EVENTS-1:0] hot;
      integer k;
      begin
         onehot_index = 5'd0;
         for (k = 0; k < NUM_EVENTS; k = k + 1) begin
            if (hot[k]) begin
               onehot_index = k[4:0];
            end
         end
      end
   endfunction

   assign any_event = |event_i;
   assign pick = onehot_index(winner);

   // ***************************************
   // Load decision
   // ***************************************
   // A read in the same cycle as a new event frees the register first,
   // so the event is loaded rather than lost
   // Events that meet a pending code are dropped; the host sees the first
   wire can_load = !interrupt_request_o || status_read_i;
   wire load = any_event && can_load;

   // ***************************************
   // Side-effect decoding
   // ***************************************
   // New connection state after an event; most events leave it alone
   function [1:0] conn_after;
      input [4:0] ev;
      input [1:0] cur;
      begin
         case (ev)
            `EV_RESEL_DONE: conn_after = `CONN_TARGET;
            `EV_SEL_DONE: conn_after = `CONN_INIT;
            `EV_RESEL_MISMATCH: conn_after = `CONN_INIT;
            `EV_BUS_FREE: conn_after = `CONN_DISC;
            `EV_SEL_TIMEOUT: conn_after = `CONN_DISC;
            `EV_SEL_ABORT: conn_after = `CONN_DISC;
            default: conn_after = cur;
         endcase
      end
   endfunction

   // Events that leave the bus acknowledge asserted for the host
   function holds_ack;
      input [4:0] ev;
      begin
         holds_ack = (ev == `EV_MSGIN_PAUSE) || (ev == `EV_RESEL_MISMATCH_ADV);
      end
   endfunction

   // Only the advanced-mode mismatch exposes who reselected us
   function captures_source;
      input [4:0] ev;
      begin
         captures_source = (ev == `EV_RESEL_MISMATCH_ADV);
      end
   endfunction

   // Guard against reserved codes; cheap, and keeps a bad index harmless
   function is_reserved;
      input [7:0] code;
      begin
         is_reserved = (code == 8'h12) || (code == 8'h17) || (code == 8'h25) || (code == 8'h26);
      end
   endfunction

   // ***************************************
   // Next values
   // ***************************************
   wire [7:0] coded = encode(pick, attention_i, phase_code_field_i);

   reg [7:0] next_status;
   reg next_irq;
   reg [1:0] next_conn;
   reg next_ack;
   reg [2:0] next_source_id;
   reg [2:0] next_source_lun;

   // Status: new code on a load, otherwise held
   always @* begin
      next_status = status_code_bits_o;
      if (load) begin
         next_status = is_reserved(coded) ? {`GRP_TERM, 4'h0} : coded;
      end
   end

   // Request: set by a load, dropped by a read; a load wins a tie
   always @* begin
      next_irq = interrupt_request_o;
      if (load) begin
         next_irq = 1'b1;
      end else if (status_read_i) begin
         next_irq = 1'b0;
      end
   end

   // Connection state and acknowledge hold follow the loaded event
   always @* begin
      next_conn = conn_state_o;
      next_ack = ack_hold_o;
      if (load) begin
         next_conn = conn_after(pick, conn_state_o);
         next_ack = holds_ack(pick);
      end
   end

   // Reselector ID and LUN stay from the last advanced-mode mismatch until the next one
   always @* begin
      next_source_id = source_id_o;
      next_source_lun = source_lun_o;
      if (load && captures_source(pick)) begin
         next_source_id = resel_id_i;
         next_source_lun = resel_lun_i;
      end
   end

   // ***************************************
   // Status code register
   // ***************************************
   // Only a load moves it, so the code holds from interrupt to read or reset
   // Reset obeys the clock enable too, so a frozen block stays frozen
   always @(posedge core_clk_i) begin
      if (clk_en_i) begin
         if (srst_i) begin
            status_code_bits_o <= `STATUS_RESET;
         end else begin
            status_code_bits_o <= next_status;
         end
      end
   end

   // ***************************************
   // Interrupt request
   // ***************************************
   // Level request; the host sees it one cycle after the load
   always @(posedge core_clk_i) begin
      if (clk_en_i) begin
         if (srst_i) begin
            interrupt_request_o <= `FLAG_RESET;
         end else begin
            interrupt_request_o <= next_irq;
         end
      end
   end

   // ***************************************
   // Connection state
   // ***************************************
   // Only the events named in conn_after move it
   always @(posedge core_clk_i) begin
      if (clk_en_i) begin
         if (srst_i) begin
            conn_state_o <= `CONN_DISC;
         end else begin
            conn_state_o <= next_conn;
         end
      end
   end

   // ***************************************
   // Acknowledge hold
   // ***************************************
   // Stays held until the next code is loaded
   always @(posedge core_clk_i) begin
      if (clk_en_i) begin
         if (srst_i) begin
            ack_hold_o <= `FLAG_RESET;
         end else begin
            ack_hold_o <= next_ack;
         end
      end
   end

   // ***************************************
   // Reselector ID
   // ***************************************
   // Kept until the next advanced-mode mismatch
   always @(posedge core_clk_i) begin
      if (clk_en_i) begin
         if (srst_i) begin
            source_id_o <= `SOURCE_RESET;
         end else begin
            source_id_o <= next_source_id;
         end
      end
   end

   // ***************************************
   // Reselector LUN
   // ***************************************
   // Captured together with the ID
   always @(posedge core_clk_i) begin
      if (clk_en_i) begin
         if (srst_i) begin
            source_lun_o <= `SOURCE_RESET;
         end else begin
            source_lun_o <= next_source_lun;
         end
      end
   end

endmodule

// ===== testbench/scsi_int_host_model.sv
// Host model that reads the status register a set number of cycles after an interrupt
`timescale 1ns/1ps
module scsi_int_host_model (
   input logic core_clk_i,
   input logic en_i,
   input logic irq_i,
   input logic [3:0] delay_i,
   output logic read_o = 1'b0
);
   logic [3:0] cnt = 4'h0;
   // One-cycle read, so a second read never swallows a fresh code
   always @(posedge core_clk_i) begin
      read_o <= en_i && irq_i && !read_o && cnt == delay_i;
      cnt <= (en_i && irq_i && !read_o) ? cnt + 4'h1 : 4'h0;
   end
endmodule

// ===== testbench/scsi_int_status_asserts.sv
// Port checks for the SCSI interrupt status encoder
`timescale 1ns/1ps
module scsi_int_status_asserts #(parameter NUM_EVENTS = 20) (
   input logic core_clk_i, srst_i, clk_en_i, attention_i, status_read_i, interrupt_request_o,
   input logic [NUM_EVENTS-1:0] event_i,
   input logic [2:0] phase_code_field_i,
   input logic [7:0] status_code_bits_o,
   input logic [1:0] conn_state_o
);
   wire tk = clk_en_i && (!interrupt_request_o || status_read_i);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_load;
      tk && |event_i;
   endsequence
   chk_resel_code: assert property (tk && event_i == 1 |=> status_code_bits_o == 8'h10 && conn_state_o == 2'd1)
      else $error("reselect code wrong");
   chk_sel_code: assert property (tk && event_i == 2 |=> status_code_bits_o == 8'h11 && conn_state_o == 2'd2)
      else $error("select code wrong");
   chk_tgt_atn: assert property (tk && event_i == 4 |=> status_code_bits_o == 8'h13 + $past(attention_i))
      else $error("target done code wrong");
   chk_xfer_phase: assert property (tk && event_i == 32 |=> status_code_bits_o == {5'h03, $past(phase_code_field_i)})
      else $error("transfer done phase wrong");
   chk_bad_phase: assert property (tk && event_i == 20'h80000 |=> status_code_bits_o[7:3] == 5'h09)
      else $error("bad phase code wrong");
   chk_irq_set: assert property (s_load |=> interrupt_request_o)
      else $error("interrupt not raised");
   chk_code_hold: assert property (interrupt_request_o && !status_read_i |=> $stable(status_code_bits_o))
      else $error("code changed while pending");
   chk_no_reserved: assert property (interrupt_request_o |-> !(status_code_bits_o inside {8'h12, 8'h17, 8'h25, 8'h26}))
      else $error("reserved code seen");
endmodule
bind scsi_interrupt_status_encoder scsi_int_status_asserts #(.NUM_EVENTS(NUM_EVENTS)) i_scsi_int_status_asserts (
   .core_clk_i, .srst_i, .clk_en_i, .attention_i, .status_read_i, .interrupt_request_o, .event_i,
   .phase_code_field_i, .status_code_bits_o, .conn_state_o);

// ===== testbench/scsi_interrupt_status_encoder_tb.sv
// Self-checking testbench for the SCSI interrupt status encoder
`timescale 1ns/1ps
module scsi_interrupt_status_encoder_tb;
   logic core_clk_i = 1'b0, srst_i = 1'b1, atn = 1'b0, man_rd = 1'b0, host_en = 1'b0, irq, host_rd;
   logic clk_en = 1'b1, ack;
   logic [1:0] cst;
   logic [2:0] sid, slun;
   logic [19:0] ev = 20'h0;
   logic [2:0] ph = 3'h0;
   logic [3:0] dly = 4'h0;
   logic [7:0] code;
   logic [7:0] tbl [20] = '{8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h18, 8'h20, 8'h21, 8'h22, 8'h23,
      8'h27, 8'h28, 8'h40, 8'h41, 8'h42, 8'h43, 8'h45, 8'h46, 8'h47, 8'h48};
   int n_mismatch = 0, checks_done = 0;
   initial forever #2.5 core_clk_i = ~core_clk_i;
   scsi_interrupt_status_encoder i_scsi_interrupt_status_encoder (.core_clk_i, .srst_i, .clk_en_i(clk_en),
      .event_i(ev), .attention_i(atn), .phase_code_field_i(ph), .resel_id_i(ph), .resel_lun_i(~ph),
      .status_read_i(man_rd | host_rd), .status_code_bits_o(code), .interrupt_request_o(irq),
      .conn_state_o(cst), .ack_hold_o(ack), .source_id_o(sid), .source_lun_o(slun));
   scsi_int_host_model i_scsi_int_host_model (.core_clk_i, .en_i(host_en), .irq_i(irq), .delay_i(dly),
      .read_o(host_rd));
   task automatic step(int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic fire(logic [19:0] e, logic a, logic [2:0] p);
      ev = e;
      atn = a;
      ph = p;
      step(1);
      ev = 20'h0;
   endtask
   task automatic t_codes;
      logic [7:0] exp;
      host_en = 1'b1;
      for (int i = 0; i < 20; i++) begin
         exp = tbl[i] + ((i == 2 || i == 9 || i == 15) ? i[0] : 0) + ((i == 5 || i == 11 || i == 19) ? i[2:0] : 0);
         dly = i[1:0];
         fire(20'h1 << i, i[0], i[2:0]);
         check(code, exp);
         check({7'h0, irq}, 8'h01);
         step(8);
         check({7'h0, irq}, 8'h00);
      end
      $display("t_codes done");
   endtask
   task automatic t_hold;
      host_en = 1'b0;
      fire(20'h2, 1'b0, 3'h0);
      fire(20'h1000, 1'b0, 3'h0);
      step(3);
      check(code, 8'h11);
      man_rd = 1'b1;
      // Read and two events together: the lower index is loaded
      fire(20'h30, 1'b0, 3'h6);
      man_rd = 1'b0;
      check(code, 8'h16);
      check({7'h0, irq}, 8'h01);
      $display("t_hold done");
   endtask
   task automatic rd;
      man_rd = 1'b1;
      step(1);
      man_rd = 1'b0;
   endtask
   task automatic t_state;
      rd;
      check({7'h0, irq}, 8'h00);
      fire(20'h1, 1'b0, 3'h0);
      check({6'h0, cst}, 8'h01);
      rd;
      fire(20'h400, 1'b0, 3'h5);
      check(code, 8'h27);
      check({7'h0, ack}, 8'h01);
      check({5'h0, sid}, 8'h05);
      check({5'h0, slun}, 8'h02);
      rd;
      fire(20'h2, 1'b0, 3'h0);
      check({6'h0, cst}, 8'h02);
      check({7'h0, ack}, 8'h00);
      rd;
      fire(20'h40, 1'b0, 3'h0);
      check(code, 8'h20);
      check({7'h0, ack}, 8'h01);
      rd;
      fire(20'h2000, 1'b0, 3'h0);
      check({6'h0, cst}, 8'h00);
      rd;
      fire(20'h20000, 1'b0, 3'h0);
      check({6'h0, cst}, 8'h02);
      rd;
      fire(20'h4000, 1'b0, 3'h0);
      check({6'h0, cst}, 8'h00);
      rd;
      fire(20'h1, 1'b0, 3'h0);
      rd;
      fire(20'h100, 1'b0, 3'h0);
      check({6'h0, cst}, 8'h00);
      check(code, 8'h22);
      check({5'h0, sid}, 8'h05);
      $display("t_state done");
   endtask
   task automatic t_enable_reset;
      rd;
      clk_en = 1'b0;
      fire(20'h2, 1'b0, 3'h0);
      check({7'h0, irq}, 8'h00);
      check(code, 8'h22);
      clk_en = 1'b1;
      fire(20'h2, 1'b0, 3'h0);
      check(code, 8'h11);
      srst_i = 1'b1;
      step(1);
      srst_i = 1'b0;
      check(code, 8'h00);
      check({7'h0, irq}, 8'h00);
      fire(20'h8, 1'b0, 3'h0);
      check(code, 8'h15);
      $display("t_enable_reset done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      step(12);
      srst_i = 1'b0;
      check(code, 8'h00);
      t_codes;
      t_hold;
      t_state;
      t_enable_reset;
      test_done;
   end
   initial begin
      #20000;
      n_mismatch++;
      test_done;
   end
endmodule
